// File: core/vtf_filter.sv
// vtf_filter: per-port vlan tag classification and egress tag rewriting
// assumes: frame headers arrive parsed, egress port already chosen,
// configuration inputs come from logic on the same clock
// Function
// - untagged frames get a tag carrying the port default vid, then forward
// - unaware port: tpid 8100 frame gains an outer tag, becoming double
// - unaware port: tagged frame with tpid other than 8100 is dropped
// - frames leaving an unaware port carry tpid 8100
// - egress tagging setting decides final tagging after tpid handling
// - customer port: tpid 8100 frames forward without an added tag
// - customer port: tagged frames not tpid 8100 are discarded
// - service ports forward 8100 and own tpid, discard other tags
// - a configurable ethertype serves as custom service port tpid
// - frames leaving a service port carry tpid 88a8, a custom service port its custom ethertype
// - frames leaving a customer port carry tpid 8100
// - port default vid accepts 1 to 4095, resets to 1
// - egress settings: untag default vid, tag all, untag all
`timescale 1ns/1ps
module vtf_filter #(
	parameter int NUM_PORTS = 8,
	parameter int PW        = 3
) (
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	// configuration write
	input  wire logic                          cfg_wr,
	input  wire logic [PW-1:0]                 cfg_port,
	input  vtf_pkg::vtf_port_kind_type         cfg_type,
	input  wire logic [11:0]                   cfg_pvid,
	input  vtf_pkg::vtf_tx_tag_type            cfg_tx_tag,
	input  wire logic                          cus_wr,
	input  wire logic [15:0]                   cus_ethertype,
	// received frame header
	input  wire logic                          in_valid,
	output logic                               in_ready,
	input  wire logic [PW-1:0]                 in_port,
	input  wire logic [PW-1:0]                 in_eport,
	input  wire logic                          in_tagged,
	input  wire logic [15:0]                   in_tpid,
	input  wire logic [11:0]                   in_vid,
	// transmitted frame header
	output logic                               out_valid,
	input  wire logic                          out_ready,
	output logic [PW-1:0]                      out_port,
	output logic                               out_outer_en,
	output logic [15:0]                        out_outer_tpid,
	output logic [11:0]                        out_vid,
	output logic                               out_inner_en,
	output logic [15:0]                        out_inner_tpid,
	output logic [11:0]                        out_inner_vid,
	// status
	output logic                               drop_pulse,
	output logic [15:0]                        drop_count,
	output logic [15:0]                        cus_ethertype_q
);
	localparam int WW = vtf_pkg::EPORT_LSB + PW;

	// refuse port counts the index width cannot address
	initial begin
		if (NUM_PORTS < 1 || (1 << PW) < NUM_PORTS)
			$error("vtf_filter: PW too small for NUM_PORTS");
	end

	// per-port configuration state
	vtf_pkg::vtf_port_kind_type type_q [NUM_PORTS];
	vtf_pkg::vtf_tx_tag_type    tx_q   [NUM_PORTS];
	logic [11:0]                pvid_q [NUM_PORTS];

	// one configuration slot per port; zero pvid is refused
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		wire sel = cfg_wr & (cfg_port == PW'(p));
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				type_q[p] <= vtf_pkg::TYPE_RESET;
				tx_q[p]   <= vtf_pkg::TX_RESET;
				pvid_q[p] <= vtf_pkg::PVID_RESET;
			end else if (sel) begin
				type_q[p] <= cfg_type;
				tx_q[p]   <= cfg_tx_tag;
				if (cfg_pvid != vtf_pkg::VID_ZERO)
					pvid_q[p] <= cfg_pvid;
			end
		end
	end

	// custom service tag ethertype
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			cus_ethertype_q <= vtf_pkg::CUSTOM_RESET;
		else if (cus_wr)
			cus_ethertype_q <= cus_ethertype;
	end

	// ingress lookup by receiving port
	vtf_pkg::vtf_port_kind_type rx_type;
	logic [11:0]                rx_pvid;
	assign rx_type = type_q[in_port];
	assign rx_pvid = pvid_q[in_port];

	// ingress classification
	wire        rx_unaware = (rx_type == vtf_pkg::PT_UNAWARE);
	wire        rx_sport   = (rx_type == vtf_pkg::PT_SPORT);
	wire        rx_custom  = (rx_type == vtf_pkg::PT_SCUSTOM);
	wire        is_ctag    = (in_tpid == vtf_pkg::TPID_CTAG);
	wire [15:0] own_stag   = rx_custom ? cus_ethertype_q : vtf_pkg::TPID_STAG;
	wire        is_stag    = (rx_sport | rx_custom) & (in_tpid == own_stag);
	wire        accept     = !in_tagged | is_ctag | is_stag;
	wire        take       = in_valid & in_ready;
	wire        push       = take & accept;
	wire        drop       = take & !accept;

	// tag carried forward: pvid for untagged or unaware, else frame vid
	wire        use_pvid   = !in_tagged | rx_unaware;
	wire [11:0] push_vid   = use_pvid ? rx_pvid : in_vid;
	wire        push_inner = in_tagged & rx_unaware;
	wire [WW-1:0] push_word = {in_eport, push_vid, push_inner, in_vid};

	// buffer between ingress and egress
	logic          f_valid;
	logic [WW-1:0] f_data;
	wire           pop = f_valid & (!out_valid | out_ready);

	vtf_fifo #(
		.WIDTH (WW),
		.DEPTH (vtf_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (in_valid & accept),
		.in_ready  (in_ready),
		.in_data   (push_word),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data)
	);

	// egress fields and lookup by transmitting port
	wire [PW-1:0] e_port  = f_data[vtf_pkg::EPORT_LSB +: PW];
	wire [11:0]   e_vid   = f_data[vtf_pkg::VID_LSB +: vtf_pkg::VID_W];
	wire          e_inner = f_data[vtf_pkg::INNER_BIT];
	wire [11:0]   e_ivid  = f_data[vtf_pkg::IVID_LSB +: vtf_pkg::VID_W];
	vtf_pkg::vtf_port_kind_type e_type;
	vtf_pkg::vtf_tx_tag_type    e_tx;
	logic [11:0]                e_pvid;
	assign e_type = type_q[e_port];
	assign e_tx   = tx_q[e_port];
	assign e_pvid = pvid_q[e_port];

	// egress tpid by port type
	logic [15:0] e_tpid;
	always_comb begin
		unique case (e_type)
			vtf_pkg::PT_UNAWARE: e_tpid = vtf_pkg::TPID_CTAG;
			vtf_pkg::PT_CPORT:   e_tpid = vtf_pkg::TPID_CTAG;
			vtf_pkg::PT_SPORT:   e_tpid = vtf_pkg::TPID_STAG;
			vtf_pkg::PT_SCUSTOM: e_tpid = cus_ethertype_q;
		endcase
	end

	// egress tagging setting applied last
	logic e_tag;
	always_comb begin
		case (e_tx)
			vtf_pkg::TX_TAG_ALL:   e_tag = 1'b1;
			vtf_pkg::TX_UNTAG_ALL: e_tag = 1'b0;
			default:               e_tag = (e_vid != e_pvid);
		endcase
	end

	// output header register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_valid      <= 1'b0;
			out_port       <= '0;
			out_outer_en   <= 1'b0;
			out_outer_tpid <= vtf_pkg::TPID_CTAG;
			out_vid        <= vtf_pkg::VID_ZERO;
			out_inner_en   <= 1'b0;
			out_inner_tpid <= vtf_pkg::TPID_CTAG;
			out_inner_vid  <= vtf_pkg::VID_ZERO;
		end else if (pop) begin
			out_valid      <= 1'b1;
			out_port       <= e_port;
			out_outer_en   <= e_tag;
			out_outer_tpid <= e_tpid;
			out_vid        <= e_vid;
			out_inner_en   <= e_inner;
			out_inner_tpid <= vtf_pkg::TPID_CTAG;
			out_inner_vid  <= e_ivid;
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

	// drop pulse and saturating drop counter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drop_pulse <= 1'b0;
			drop_count <= 16'h0000;
		end else begin
			drop_pulse <= drop;
			if (drop && drop_count != 16'hffff)
				drop_count <= drop_count + 16'h0001;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ingress take and egress pop sequences
	sequence s_take_foreign(vtf_pkg::vtf_port_kind_type t);
		take && in_tagged && rx_type == t && !is_ctag;
	endsequence
	sequence s_pop_type(vtf_pkg::vtf_port_kind_type t);
		pop && e_type == t;
	endsequence

	a_untag_pvid: assert property (
		push && !in_tagged |-> push_vid == rx_pvid && !push_inner)
		else $error("untagged frame not given port vid");
	a_double_tag: assert property (
		push && rx_unaware && in_tagged |->
		push_inner && push_word[11:0] == in_vid && push_vid == rx_pvid)
		else $error("unaware port did not add outer tag");
	a_unaware_drop: assert property (
		s_take_foreign(vtf_pkg::PT_UNAWARE) |=> drop_pulse)
		else $error("unaware port kept foreign tag");
	a_cport_drop: assert property (
		s_take_foreign(vtf_pkg::PT_CPORT) |=> drop_pulse && $changed(drop_count)
		|| drop_count == 16'hffff)
		else $error("customer port kept foreign tag");
	a_cport_pass: assert property (
		take && in_tagged && is_ctag && rx_type == vtf_pkg::PT_CPORT |->
		push && !push_inner && push_vid == in_vid)
		else $error("customer port altered its tag");
	a_sport_filter: assert property (
		take && in_tagged && (rx_sport || rx_custom) |=>
		drop_pulse != ($past(in_tpid) == 16'h8100 ||
		$past(in_tpid) == $past(rx_custom ? cus_ethertype_q : 16'h88a8)))
		else $error("service port tag filter wrong");
	a_unaware_tpid: assert property (
		s_pop_type(vtf_pkg::PT_UNAWARE) |=> out_outer_tpid == 16'h8100)
		else $error("unaware egress tpid wrong");
	a_cport_tpid: assert property (
		s_pop_type(vtf_pkg::PT_CPORT) |=> out_outer_tpid == 16'h8100)
		else $error("customer egress tpid wrong");
	a_sport_tpid: assert property (
		s_pop_type(vtf_pkg::PT_SPORT) |=> out_outer_tpid == 16'h88a8)
		else $error("service egress tpid wrong");
	a_custom_tpid: assert property (
		s_pop_type(vtf_pkg::PT_SCUSTOM) |=>
		out_outer_tpid == $past(cus_ethertype_q))
		else $error("custom egress tpid wrong");
	a_tx_setting: assert property (
		pop && e_tx != vtf_pkg::TX_UNTAG_PVID |=>
		out_valid && out_outer_en == ($past(e_tx) == vtf_pkg::TX_TAG_ALL))
		else $error("egress tagging setting ignored");
	a_untag_pvid_tx: assert property (
		pop && e_tx == vtf_pkg::TX_UNTAG_PVID |=>
		out_outer_en == ($past(e_vid) != $past(e_pvid)))
		else $error("default vid not untagged on egress");
	a_pvid_nonzero: assert property (
		cfg_wr |=> pvid_q[$past(cfg_port)] != 12'h000)
		else $error("port default vid became zero");

	// configuration checks: a write lands in the addressed slot, pvid only when nonzero
	a_cfg_write: assert property (
		cfg_wr |=> type_q[$past(cfg_port)] == $past(cfg_type) &&
		tx_q[$past(cfg_port)] == $past(cfg_tx_tag))
		else $error("port configuration not written");
	a_pvid_write: assert property (
		cfg_wr && cfg_pvid != 12'h000 |=>
		pvid_q[$past(cfg_port)] == $past(cfg_pvid))
		else $error("port default vid not written");

	// ingress acceptance checks
	a_unaware_keep: assert property (
		take && in_tagged && rx_unaware && is_ctag |-> push && push_inner)
		else $error("unaware port refused customer tagged frame");
	a_sport_pass: assert property (
		take && in_tagged && is_ctag && (rx_sport || rx_custom) |->
		push && !push_inner && push_vid == in_vid)
		else $error("service port altered customer tagged frame");
	a_custom_accept: assert property (
		take && in_tagged && rx_custom && in_tpid == cus_ethertype_q |->
		push && push_vid == in_vid)
		else $error("custom port refused its own tpid");
	a_drop_count: assert property (
		drop && drop_count != 16'hffff |=>
		drop_count == $past(drop_count) + 16'h0001)
		else $error("discard not counted");

	// egress sequences: a stalled header must not move under the consumer
	sequence s_out_stall;
		out_valid && !out_ready;
	endsequence

	a_out_hold: assert property (
		s_out_stall |=> out_valid && $stable(out_outer_en) &&
		$stable(out_outer_tpid) && $stable(out_vid) && $stable(out_port))
		else $error("egress header changed while stalled");
	a_inner_tpid: assert property (
		out_valid && out_inner_en |-> out_inner_tpid == 16'h8100)
		else $error("inner tag tpid not customer tpid");
endmodule

// File: core/vtf_pkg.sv
// vtf_pkg: shared constants and types of the vlan port type tag filter
// assumes: included before any module of the block, nothing imported
package vtf_pkg;

	// tag protocol identifiers
	localparam logic [15:0] TPID_CTAG    = 16'h8100;
	localparam logic [15:0] TPID_STAG    = 16'h88a8;
	localparam logic [15:0] CUSTOM_RESET = 16'h88a8;

	// vlan identifier width, reset pvid and the illegal zero value
	localparam int          VID_W      = 12;
	localparam logic [11:0] PVID_RESET = 12'h001;
	localparam logic [11:0] VID_ZERO   = 12'h000;

	// port type encoding, gray order along the usual path
	typedef enum logic [1:0] {
		PT_UNAWARE = 2'h0,
		PT_CPORT   = 2'h1,
		PT_SPORT   = 2'h3,
		PT_SCUSTOM = 2'h2
	} vtf_port_kind_type;

	// egress tagging setting
	typedef enum logic [1:0] {
		TX_UNTAG_PVID = 2'h0,
		TX_TAG_ALL    = 2'h1,
		TX_UNTAG_ALL  = 2'h2
	} vtf_tx_tag_type;

	localparam vtf_port_kind_type TYPE_RESET = PT_CPORT;
	localparam vtf_tx_tag_type    TX_RESET   = TX_UNTAG_PVID;

	// fifo word layout: {eport, vid, inner, ivid}
	localparam int IVID_LSB  = 0;
	localparam int INNER_BIT = 12;
	localparam int VID_LSB   = 13;
	localparam int EPORT_LSB = 25;

	// fifo depth
	localparam int FIFO_DEPTH = 32;

endpackage

// File: core/vtf_fifo.sv
// vtf_fifo: synchronous first-in first-out buffer with valid and ready
// assumes: one clock, producer and consumer in the same domain
`timescale 1ns/1ps
module vtf_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 32
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// refuse shapes the pointer wrap cannot serve
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("vtf_fifo: depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	// occupancy after this cycle
	assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_valid  = (count != '0);
	assign out_data   = mem[rd_ptr];

	// pointers, count and registered ready
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			count    <= '0;
			in_ready <= 1'b0;
		end else begin
			wr_ptr   <= wr_ptr + AW'(push);
			rd_ptr   <= rd_ptr + AW'(pop);
			count    <= next_count;
			in_ready <= (next_count != (AW+1)'(DEPTH));
		end
	end

	// storage has no reset
	always_ff @(posedge clock) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_fifo_no_over: assert property (count <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
	a_fifo_full_ready: assert property (count == (AW+1)'(DEPTH) |-> !in_ready)
		else $error("fifo ready while full");
endmodule

// File: sim/vtf_sink.sv
// vtf_sink: link partner that takes transmitted frame headers
// assumes: same clock as the filter, stall driven by the bench
`timescale 1ns/1ps
module vtf_sink (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        stall,
	input  wire logic        out_valid,
	output logic             out_ready,
	input  wire logic [41:0] hdr,
	output logic      [41:0] cap,
	output logic      [15:0] rx_count
);
	// ready moves at the falling edge, away from the sampling edge
	always @(negedge clock or negedge rst_n) begin
		if (!rst_n)
			out_ready <= 1'b0;
		else
			out_ready <= !stall;
	end
	// keep the last header taken and count them
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cap      <= '0;
			rx_count <= '0;
		end else if (out_valid && out_ready) begin
			cap      <= hdr;
			rx_count <= rx_count + 16'h1;
		end
	end
endmodule

// File: sim/testbench.sv
// testbench: configures ports and pushes frame headers through the filter
// assumes: vtf_pkg, vtf_fifo, vtf_filter and vtf_sink compiled first
`timescale 1ns/1ps
module testbench;
	logic                              clock, rst_n, cfg_wr, cus_wr, stall;
	logic                              in_valid, in_ready, in_tagged;
	logic                              out_valid, out_ready, drop_pulse;
	logic                              out_outer_en, out_inner_en;
	logic [2:0]                        cfg_port, in_port, in_eport, out_port;
	logic [15:0]                       out_inner_tpid;
	vtf_pkg::vtf_port_kind_type        cfg_type;
	vtf_pkg::vtf_tx_tag_type           cfg_tx_tag;
	logic [11:0]                       cfg_pvid, in_vid, out_vid;
	logic [11:0]                       out_inner_vid;
	logic [15:0]                       cus_ethertype, in_tpid, out_outer_tpid;
	logic [15:0]                       drop_count, cus_ethertype_q, rx_count;
	logic [41:0]                       cap;
	int                                miscompares, n_checks, nd;

	vtf_filter uut (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr),
		.cfg_port(cfg_port), .cfg_type(cfg_type), .cfg_pvid(cfg_pvid),
		.cfg_tx_tag(cfg_tx_tag), .cus_wr(cus_wr),
		.cus_ethertype(cus_ethertype), .in_valid(in_valid),
		.in_ready(in_ready), .in_port(in_port), .in_eport(in_eport),
		.in_tagged(in_tagged), .in_tpid(in_tpid), .in_vid(in_vid),
		.out_valid(out_valid), .out_ready(out_ready), .out_port(out_port),
		.out_outer_en(out_outer_en), .out_outer_tpid(out_outer_tpid),
		.out_vid(out_vid), .out_inner_en(out_inner_en),
		.out_inner_tpid(out_inner_tpid), .out_inner_vid(out_inner_vid),
		.drop_pulse(drop_pulse), .drop_count(drop_count),
		.cus_ethertype_q(cus_ethertype_q));
	vtf_sink link (.clock(clock), .rst_n(rst_n), .stall(stall),
		.out_valid(out_valid), .out_ready(out_ready), .hdr({out_outer_en,
		out_outer_tpid, out_vid, out_inner_en, out_inner_vid}),
		.cap(cap), .rx_count(rx_count));

	// free running clock, 20 ns period
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic end_sim;
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a wait that ran out ends the run
	task automatic fail;
		miscompares++;
		end_sim;
	endtask

	task automatic cfg(input logic [2:0] p, input vtf_pkg::vtf_port_kind_type t,
		input logic [11:0] v, input vtf_pkg::vtf_tx_tag_type x);
		@(negedge clock);
		cfg_wr = 1'b1;
		cfg_port = p;
		cfg_type = t;
		cfg_pvid = v;
		cfg_tx_tag = x;
		@(negedge clock);
		cfg_wr = 1'b0;
	endtask

	// present one header and hold it until the edge that takes it
	task automatic send(input logic [2:0] p, e, input logic tg,
		input logic [15:0] tp, input logic [11:0] v);
		int i;
		@(negedge clock);
		{in_port, in_eport, in_tagged, in_tpid, in_vid} = {p, e, tg, tp, v};
		in_valid = 1'b1;
		for (i = 0; i < 50 && in_ready !== 1'b1; i++)
			@(negedge clock);
		if (in_ready !== 1'b1)
			fail;
		@(negedge clock);
		in_valid = 1'b0;
	endtask

	function automatic logic [42:0] ex(input logic d, oe, input logic [15:0] tp,
		input logic [11:0] v, input logic ie, input logic [11:0] iv);
		return {d, oe, tp, v, ie, iv};
	endfunction

	// one frame: drop flag, then the header seen by the link partner
	task automatic frm(input logic [2:0] p, e, input logic tg,
		input logic [15:0] tp, input logic [11:0] v, input logic [42:0] exp);
		logic [15:0] c;
		logic [42:0] got;
		int          i;
		c = rx_count;
		send(p, e, tg, tp, v);
		got[42] = drop_pulse;
		if (!exp[42]) begin
			for (i = 0; i < 20 && rx_count == c; i++)
				@(negedge clock);
			if (rx_count == c)
				fail;
			got[41:0] = cap;
			if (!exp[41])
				got[40:13] = exp[40:13];
			chk(64'(out_port), 64'(e));
			chk(64'(out_inner_tpid), 64'h8100);
		end else begin
			got[41:0] = exp[41:0];
			nd++;
		end
		chk(64'(got), 64'(exp));
	endtask

	// stall the partner, fill until refused, then drain everything
	task automatic fill;
		logic [15:0] c;
		int          n, i;
		c = rx_count;
		stall = 1'b1;
		@(negedge clock);
		{in_port, in_eport, in_tagged} = {3'h0, 3'h1, 1'b0};
		in_valid = 1'b1;
		n = 0;
		for (i = 0; i < 60 && in_ready === 1'b1; i++) begin
			@(posedge clock);
			n++;
			@(negedge clock);
		end
		in_valid = 1'b0;
		chk(64'(n >= 32 && n <= 33), 64'h1);
		stall = 1'b0;
		for (i = 0; i < 200 && rx_count != 16'(c + n); i++)
			@(negedge clock);
		chk(64'(rx_count), 64'(c + n));
	endtask

	// main sequence
	initial begin
		{rst_n, cfg_wr, cus_wr, stall, in_valid, in_tagged} = '0;
		{cfg_port, in_port, in_eport, cfg_pvid, in_vid} = '0;
		{cus_ethertype, in_tpid} = '0;
		cfg_type = vtf_pkg::PT_CPORT;
		cfg_tx_tag = vtf_pkg::TX_UNTAG_PVID;
		miscompares = 0;
		n_checks = 0;
		nd = 0;
		repeat (3) @(negedge clock);
		chk({in_ready, out_valid, cus_ethertype_q, drop_count}, 34'h88a80000);
		rst_n = 1'b1;
		frm(0, 1, 0, 0, 0, ex(0, 0, 0, 0, 0, 0));
		frm(0, 1, 1, 16'h8100, 9, ex(0, 1, 16'h8100, 9, 0, 9));
		frm(0, 1, 1, 16'h88a8, 9, ex(1, 0, 0, 0, 0, 0));
		cfg(2, vtf_pkg::PT_UNAWARE, 5, vtf_pkg::TX_TAG_ALL);
		cfg(3, vtf_pkg::PT_CPORT, 1, vtf_pkg::TX_TAG_ALL);
		frm(0, 2, 0, 0, 0, ex(0, 1, 16'h8100, 1, 0, 0));
		frm(2, 3, 1, 16'h8100, 7, ex(0, 1, 16'h8100, 5, 1, 7));
		frm(2, 3, 1, 16'h88a8, 7, ex(1, 0, 0, 0, 0, 0));
		frm(2, 1, 0, 0, 0, ex(0, 1, 16'h8100, 5, 0, 0));
		cfg(3, vtf_pkg::PT_CPORT, 1, vtf_pkg::TX_UNTAG_ALL);
		frm(0, 3, 1, 16'h8100, 9, ex(0, 0, 0, 0, 0, 9));
		cfg(4, vtf_pkg::PT_SPORT, 9, vtf_pkg::TX_TAG_ALL);
		cfg(5, vtf_pkg::PT_SPORT, 1, vtf_pkg::TX_TAG_ALL);
		frm(4, 5, 1, 16'h8100, 3, ex(0, 1, 16'h88a8, 3, 0, 3));
		frm(4, 5, 1, 16'h88a8, 3, ex(0, 1, 16'h88a8, 3, 0, 3));
		frm(4, 5, 1, 16'h9100, 3, ex(1, 0, 0, 0, 0, 0));
		@(negedge clock);
		cus_wr = 1'b1;
		cus_ethertype = 16'h9100;
		@(negedge clock);
		cus_wr = 1'b0;
		chk(64'(cus_ethertype_q), 64'h9100);
		cfg(6, vtf_pkg::PT_SCUSTOM, 2, vtf_pkg::TX_TAG_ALL);
		frm(6, 5, 1, 16'h9100, 4, ex(0, 1, 16'h88a8, 4, 0, 4));
		frm(4, 6, 1, 16'h8100, 3, ex(0, 1, 16'h9100, 3, 0, 3));
		frm(6, 5, 1, 16'h88a8, 4, ex(1, 0, 0, 0, 0, 0));
		cfg(0, vtf_pkg::PT_CPORT, 0, vtf_pkg::TX_TAG_ALL);
		frm(0, 2, 0, 0, 0, ex(0, 1, 16'h8100, 1, 0, 0));
		cfg(0, vtf_pkg::PT_CPORT, 12'hfff, vtf_pkg::TX_UNTAG_PVID);
		frm(0, 2, 0, 0, 0, ex(0, 1, 16'h8100, 12'hfff, 0, 0));
		frm(1, 0, 1, 16'h8100, 12'hfff, ex(0, 0, 0, 0, 0, 12'hfff));
		chk(64'(drop_count), 64'(nd));
		fill;
		end_sim;
	end
endmodule
